/* File: core/eeprom_array_host.sv */
// Host-side controller for an interleaved array of self-timed byte-write EEPROMs.
// Assumes all device ready/busy outputs are wired into one pulled-up line sampled on rdy_i.
`timescale 1ns/10ps
`default_nettype none
module eeprom_array_host
  import eeprom_host_pkg::*;
#(
  parameter int NDEV        = NDEV_DEF,
  parameter int BLK_LEN     = BLK_LEN_DEF,
  parameter int NBLK        = NBLK_DEF,
  parameter int WRITE_TIME  = WRITE_CYC,
  parameter int TIMEOUT_CYC = TIMEOUT_MULT * WRITE_CYC
) (
  input  wire logic              sys_clk,     // System clock, 100 MHz.
  input  wire logic              rstn,        // Synchronous reset, active low.
  input  wire logic              ce,          // Clock enable; freezes all state when low.
  input  wire cmd_t              cmd,         // Command: operation, base address, length.
  input  wire logic              cmd_valid,   // Command offered.
  output logic                   cmd_ready,   // Command taken when both high.
  input  wire logic [DW-1:0]     wr_data,     // Write byte stream.
  input  wire logic              wr_valid,    // Write byte offered.
  output logic                   wr_ready,    // Write byte taken when both high.
  output result_t                result,      // Completion pulse and outcome.
  output logic                   rdy_rise,    // Pulse on shared ready line rising.
  output logic [DEV_AW-1:0]      dev_addr,    // Address to the devices.
  output logic [NDEV-1:0]        cs_n,        // Per-device chip selects, active low.
  output logic                   we_n,        // Write strobe, active low.
  output logic                   oe_n,        // Output enable, active low.
  output logic [DW-1:0]          data_o,      // Data bus, driven value.
  output logic                   data_oe,     // Data bus driven when high.
  input  wire logic [DW-1:0]     data_i,      // Data bus, sensed value.
  input  wire logic              rdy_i        // Wired ready line, high when all idle.
);
  localparam int LG        = $clog2(NDEV);
  localparam int WE_LOW_N  = WE_LOW_CYC;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_RDY, ST_W_LOAD, ST_W_SETUP, ST_W_STB, ST_W_HOLD,
    ST_SETTLE, ST_R_ADDR, ST_R_CHECK, ST_DONE
  } st_t;

  typedef struct packed {
    st_t               st;
    op_t               op;
    logic [ARR_AW-1:0] addr;
    logic [LEN_W-1:0]  remain;
    logic [LEN_W-1:0]  blk;
    logic [DW-1:0]     wdata;
    logic [DW-1:0]     rd_byte;
    logic [NDEV-1:0]   cs_n;
    logic [NDEV-1:0]   dev_mask;
    logic              we_n;
    logic              oe_n;
    logic              data_oe;
    logic              first;
    logic              rdy_q;
    logic              rdy_rise;
    result_t           res;
  } host_state_t;

  host_state_t st_r;
  host_state_t st_nxt;

  logic              t_load;
  logic [TMR_W-1:0]  t_val;
  logic              t_exp;
  logic              to_load;
  logic              to_exp;
  logic [LG-1:0]     next_dev;
  logic [LG-1:0]     cur_dev;

  function automatic logic [NDEV-1:0] dev_sel(input logic [ARR_AW-1:0] a);
    return ~(NDEV'(1) << a[LG-1:0]);
  endfunction

  assign cur_dev  = st_r.addr[LG-1:0];
  assign next_dev = LG'(st_r.addr + ARR_AW'(1));

  always_comb begin
    st_nxt = st_r;
    t_load = 1'b0;
    t_val = '0;
    to_load = 1'b0;
    cmd_ready = 1'b0;
    wr_ready = 1'b0;
    st_nxt.res.done = 1'b0;
    st_nxt.rdy_rise = rdy_i & ~st_r.rdy_q;
    st_nxt.rdy_q = rdy_i;
    case (st_r.st)
      ST_IDLE: begin
        cmd_ready = 1'b1;
        if (cmd_valid) begin
          st_nxt.op = cmd.op;
          st_nxt.addr = cmd.base;
          st_nxt.remain = cmd.len;
          st_nxt.blk = '0;
          st_nxt.res = '0;
          st_nxt.first = 1'b1;
          st_nxt.st = ST_WAIT_RDY;
          to_load = 1'b1;
        end
      end
      ST_WAIT_RDY: begin
        if (rdy_i) begin
          st_nxt.dev_mask = '0;
          if (st_r.op == OP_FIND_EMPTY) begin
            st_nxt.cs_n = dev_sel(st_r.addr);
            st_nxt.oe_n = 1'b0;
            t_load = 1'b1;
            t_val = TMR_W'(READ_CYC - 1);
            st_nxt.st = ST_R_ADDR;
          end else begin
            st_nxt.st = (st_r.remain == '0) ? ST_DONE : ST_W_LOAD;
          end
        end else if (to_exp) begin
          // a stuck busy line ends the command with a timeout.
          st_nxt.res.timeout = 1'b1;
          st_nxt.st = ST_DONE;
        end
      end
      ST_W_LOAD: begin
        wr_ready = 1'b1;
        if (wr_valid) begin
          st_nxt.wdata = wr_data;
          st_nxt.data_oe = 1'b1;
          st_nxt.cs_n = dev_sel(st_r.addr);
          st_nxt.st = ST_W_SETUP;
        end
      end
      ST_W_SETUP: begin
        // strobe falls fresh for each byte.
        st_nxt.we_n = 1'b0;
        t_load = 1'b1;
        t_val = TMR_W'(WE_LOW_CYC - 1);
        st_nxt.st = ST_W_STB;
      end
      ST_W_STB: begin
        if (t_exp) begin
          st_nxt.we_n = 1'b1;
          st_nxt.dev_mask = st_r.dev_mask | ~st_r.cs_n;
          st_nxt.st = ST_W_HOLD;
        end
      end
      ST_W_HOLD: begin
        // data held through the strobe rise, released after.
        st_nxt.data_oe = 1'b0;
        st_nxt.cs_n = '1;
        st_nxt.addr = st_r.addr + ARR_AW'(1);
        st_nxt.remain = st_r.remain - LEN_W'(1);
        st_nxt.first = 1'b0;
        // a burst ends before it would wrap to a device already hit.
        if (st_r.remain == LEN_W'(1) || next_dev == '0) begin
          t_load = 1'b1;
          t_val = TMR_W'(BUSY_CYC - 1);
          st_nxt.st = ST_SETTLE;
        end else begin
          st_nxt.st = ST_W_LOAD;
        end
      end
      ST_SETTLE: begin
        // give busy time to appear before ready is trusted.
        if (t_exp) begin
          st_nxt.first = 1'b1;
          to_load = 1'b1;
          st_nxt.st = ST_WAIT_RDY;
        end
      end
      ST_R_ADDR: begin
        if (t_exp) begin
          st_nxt.rd_byte = data_i;
          st_nxt.cs_n = '1;
          st_nxt.oe_n = 1'b1;
          st_nxt.st = ST_R_CHECK;
        end
      end
      ST_R_CHECK: begin
        // first byte FF marks an empty block.
        if (st_r.rd_byte == EMPTY_MARK) begin
          st_nxt.res.found = 1'b1;
          st_nxt.res.found_addr = st_r.addr;
          st_nxt.st = ST_DONE;
        end else if (st_r.blk == LEN_W'(NBLK - 1)) begin
          st_nxt.st = ST_DONE;
        end else begin
          st_nxt.blk = st_r.blk + LEN_W'(1);
          st_nxt.addr = st_r.addr + ARR_AW'(BLK_LEN);
          st_nxt.cs_n = dev_sel(st_r.addr + ARR_AW'(BLK_LEN));
          st_nxt.oe_n = 1'b0;
          t_load = 1'b1;
          t_val = TMR_W'(READ_CYC - 1);
          st_nxt.st = ST_R_ADDR;
        end
      end
      ST_DONE: begin
        st_nxt.res.done = 1'b1;
        st_nxt.st = ST_IDLE;
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // strobes and selects held inactive through reset.
      st_r <= '0;
      st_r.cs_n <= '1;
      st_r.we_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      // The pulled-up ready line idles high, so no false completion edge follows reset.
      st_r.rdy_q <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  interval_timer #(.W(TMR_W)) u_step_tmr (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .load     (t_load),
    .load_val (t_val),
    .expired  (t_exp)
  );

  interval_timer #(.W(TMR_W)) u_busy_tmr (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .load     (to_load),
    .load_val (TMR_W'(TIMEOUT_CYC - 1)),
    .expired  (to_exp)
  );

  assign result   = st_r.res;
  assign rdy_rise = st_r.rdy_rise;
  assign dev_addr = st_r.addr[LG +: DEV_AW];
  assign cs_n     = st_r.cs_n;
  assign we_n     = st_r.we_n;
  assign oe_n     = st_r.oe_n;
  assign data_o   = st_r.wdata;
  assign data_oe  = st_r.data_oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !ce);

  a_cs_low_bits: assert property ((st_r.cs_n != '1) |-> (st_r.cs_n == dev_sel(st_r.addr)))
    else $error("chip select does not match low address bits");
  a_we_width: assert property ($fell(we_n) |-> ##WE_LOW_N $rose(we_n))
    else $error("write strobe low width wrong");
  a_addr_stable: assert property (!we_n |-> ($stable(dev_addr) && $stable(cs_n) && data_oe))
    else $error("address or select moved while strobe low");
  a_data_hold: assert property ($rose(we_n) |-> (data_oe && $stable(data_o) && cs_n != '1))
    else $error("data not held at strobe rise");
  a_no_same_dev: assert property ($fell(we_n) |-> (st_r.dev_mask[cur_dev] == 1'b0))
    else $error("second write to one device in a burst");
  a_settle_wait: assert property ($rose(we_n) |-> (st_r.st != ST_WAIT_RDY) [*8])
    else $error("ready sampled too soon after strobe");
  a_burst_ready: assert property ((st_r.st == ST_W_LOAD && st_r.first)
                                  |-> $past(rdy_i))
    else $error("burst began while ready line low");
  a_bus_contend: assert property (!(data_oe && !oe_n))
    else $error("host drives data while device output enabled");
  a_empty_mark: assert property ($rose(st_r.res.found) |-> $past(st_r.rd_byte) == EMPTY_MARK)
    else $error("block reported empty without FF marker");
  a_ready_edge: assert property ($rose(rdy_i) |=> rdy_rise)
    else $error("ready rise not flagged");

  c_write_done: cover property (st_r.res.done && !st_r.res.timeout && st_r.op == OP_WRITE_BLOCK);
  c_found_empty: cover property (st_r.res.done && st_r.res.found);
  c_timeout: cover property (st_r.res.done && st_r.res.timeout);
  c_two_bursts: cover property ((st_r.st == ST_SETTLE) ##[1:1000] (st_r.st == ST_W_LOAD));
endmodule // eeprom_array_host
`default_nettype wire

/* File: core/eeprom_host_pkg.sv */
// Shared constants and carrier types for the EEPROM array write controller.
// Assumes a single 100 MHz system clock and byte-wide devices on one wired ready line.
package eeprom_host_pkg;

  // Clock and timing figures, each in its own unit.
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_BUSY_NS     = 75;
  localparam int T_WRITE_MS    = 20;
  localparam int T_WE_LOW_NS   = 100;
  localparam int T_READ_NS     = 200;
  localparam int NS_PER_MS     = 1000000;

  // Least times round up to whole cycles.
  localparam int BUSY_CYC   = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC   = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC  = T_WRITE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int TIMEOUT_MULT = 2;

  // Array geometry defaults and widths.
  localparam int NDEV_DEF  = 16;
  localparam int DEV_AW    = 11;
  localparam int ARR_AW    = 16;
  localparam int LEN_W     = 16;
  localparam int DW        = 8;
  localparam int TMR_W     = 23;
  localparam int BLK_LEN_DEF = 100;
  localparam int NBLK_DEF    = 20;

  // First byte of an unused message block.
  localparam logic [DW-1:0] EMPTY_MARK = 8'hFF;

  typedef enum logic { OP_WRITE_BLOCK, OP_FIND_EMPTY } op_t;

  typedef struct packed {
    op_t               op;
    logic [ARR_AW-1:0] base;
    logic [LEN_W-1:0]  len;
  } cmd_t;

  typedef struct packed {
    logic              done;
    logic              timeout;
    logic              found;
    logic [ARR_AW-1:0] found_addr;
  } result_t;

endpackage

/* File: core/interval_timer.sv */
// Down-counting interval timer: load a count, expired is high once it reaches zero.
// Assumes the loader holds its own state while waiting for expired.
`timescale 1ns/10ps
`default_nettype none
module interval_timer #(
  parameter int W = 23
) (
  input  wire logic         sys_clk,   // System clock.
  input  wire logic         rstn,      // Synchronous reset, active low.
  input  wire logic         ce,        // Clock enable.
  input  wire logic         load,      // Load pulse.
  input  wire logic [W-1:0] load_val,  // Count to load.
  output logic              expired    // Count is zero.
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t tmr_r;
  tmr_state_t tmr_nxt;

  always_comb begin
    tmr_nxt = tmr_r;
    if (load) begin
      tmr_nxt.cnt = load_val;
    end else if (tmr_r.cnt != '0) begin
      tmr_nxt.cnt = tmr_r.cnt - W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tmr_r <= '0;
    end else if (ce) begin
      tmr_r <= tmr_nxt;
    end
  end

  assign expired = (tmr_r.cnt == '0);
endmodule // interval_timer
`default_nettype wire

/* File: bench/eeprom_dev_model.sv */
// Behavioural model of an array of self-timed byte-write EEPROMs.
// Assumes one cs_n low per strobe; ready is a wired-AND line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int N     = 4,
  parameter int WT_NS = 1000
) (
  input  wire logic [N-1:0]      cs_n,   // Chip selects.
  input  wire logic              we_n,   // Write strobe.
  input  wire logic              oe_n,   // Output enable.
  input  wire logic [DEV_AW-1:0] addr,   // Device address.
  input  wire logic [DW-1:0]     hd,     // Host data.
  input  wire logic              hoe,    // Host drives bus.
  input  wire logic              stuck,  // Hold ready low.
  output logic [DW-1:0]          bus,    // Resolved data bus.
  output logic                   rdy,    // Wired ready line.
  output var int                 lost    // Strobes dropped while busy.
);
  localparam bit VCC_OK = 1'b1;
  logic [DW-1:0] mem [N][16];
  logic [N-1:0]  wip = '0;
  logic [N-1:0]  pull = '0;
  logic [DW-1:0] pat = 8'h5A;
  initial begin
    lost = 0;
    foreach (mem[i, j]) mem[i][j] = 8'hFF;
    forever #10 pat = ~pat;
  end
  for (genvar g = 0; g < N; g++) begin : g_dev
    logic [3:0]    la;
    logic [DW-1:0] wd;
    logic          armed = 1'b0;
    // Arm only on a fall while idle and powered.
    always @(negedge we_n) begin
      if (!cs_n[g] && wip[g]) begin
        lost++;
      end else if (!cs_n[g] && VCC_OK) begin
        armed = 1'b1;
        la = addr[3:0];
      end
    end
    // Data on rise, busy 75 ns later.
    always @(posedge we_n) begin
      if (armed) begin
        armed = 1'b0;
        wd = hd;
        wip[g] = 1'b1;
        #75 pull[g] = 1'b1;
        #(WT_NS) mem[g][la] = wd;
        pull[g] = 1'b0;
        wip[g] = 1'b0;
      end
    end
  end
  // Open-drain outputs on one pulled-up line.
  assign rdy = ~(|pull) & ~stuck;
  // Busy devices float the bus; a released bus toggles.
  always_comb begin
    bus = pat;
    for (int i = 0; i < N; i++) begin
      if (!cs_n[i] && !oe_n && !wip[i]) bus = mem[i][addr[3:0]];
    end
    if (hoe) bus = hd;
  end
endmodule // eeprom_dev_model
`default_nettype wire

/* File: bench/test_eeprom_array_host.sv */
// Self-checking bench for the EEPROM array write controller.
// Assumes the device model in eeprom_dev_model.sv and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_eeprom_array_host
  import eeprom_host_pkg::*;
();
  localparam int NDV = 4;
  localparam int WT  = 100;
  logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
  logic stuck = 1'b0, cmd_ready, wr_ready, rdy_rise, we_n, oe_n, data_oe, rdy_i;
  cmd_t              cmd = '0;
  result_t           result, res;
  logic [DW-1:0]     wr_data = '0, data_o, data_i;
  logic [DEV_AW-1:0] dev_addr;
  logic [NDV-1:0]    cs_n;
  int lost, cyc, error_cnt = 0, check_count = 0, rise_cnt = 0;
  time t0;

  eeprom_array_host #(.NDEV(NDV), .BLK_LEN(5), .NBLK(4), .WRITE_TIME(WT),
    .TIMEOUT_CYC(300)) eeprom_array_host_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .result(result), .rdy_rise(rdy_rise),
    .dev_addr(dev_addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .data_o(data_o),
    .data_oe(data_oe), .data_i(data_i), .rdy_i(rdy_i));
  eeprom_dev_model #(.N(NDV), .WT_NS(WT * 10)) eeprom_dev_model_i (.cs_n(cs_n),
    .we_n(we_n), .oe_n(oe_n), .addr(dev_addr), .hd(data_o), .hoe(data_oe),
    .stuck(stuck), .bus(data_i), .rdy(rdy_i), .lost(lost));

  initial forever #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (rdy_rise === 1'b1) rise_cnt++;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Offers a command, streams its bytes, waits for done and keeps the result.
  task automatic run_cmd(input op_t op, input logic [15:0] base, input logic [15:0] len);
    int n;
    int i;
    n = 0;
    i = 0;
    @(posedge sys_clk);
    #1 cmd = '{op, base, len};
    t0 = $time;
    cmd_valid = 1'b1;
    while (n < 50 && cmd_ready !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    // Bytes wait through whole burst gaps; a timed-out command ends the wait by its done pulse.
    wr_data = 8'(16 + base);
    wr_valid = (op == OP_WRITE_BLOCK && len != 0);
    n = 0;
    while (n < 3000 && result.done !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (wr_valid && wr_ready === 1'b1) begin
        @(posedge sys_clk);
        #1 i++;
        wr_data = 8'(16 + base + i);
        wr_valid = (i < len);
      end
    end
    wr_valid = 1'b0;
    res = result;
    cyc = int'(($time - t0) / 10);
    chk("done", 1, res.done);
  endtask

  task automatic t_reset();
    chk("cs_n", 4'hF, cs_n);
    chk("we_n", 1, we_n);
    chk("data_oe", 0, data_oe);
    repeat (2) @(posedge sys_clk);
    #1 chk("reset rises", 0, rise_cnt);
    // A frozen controller must not act on an offered command.
    ce = 1'b0;
    cmd = '{OP_FIND_EMPTY, 16'd0, 16'd0};
    cmd_valid = 1'b1;
    repeat (30) @(posedge sys_clk);
    #1 chk("frozen oe_n", 1, oe_n);
    chk("frozen cs_n", 4'hF, cs_n);
    cmd_valid = 1'b0;
    ce = 1'b1;
    $display("test reset done");
  endtask

  task automatic t_write();
    rise_cnt = 0;
    run_cmd(OP_WRITE_BLOCK, 0, 6);
    chk("timeout", 0, res.timeout);
    for (int a = 0; a < 6; a++) begin
      chk("mem", 8'(16 + a), eeprom_dev_model_i.mem[a % NDV][a / NDV]);
    end
    chk("lost", 0, lost);
    chk("rises", 2, rise_cnt);
    run_cmd(OP_WRITE_BLOCK, 8, 4);
    chk("burst time", 1, cyc > WT && cyc < 2 * WT);
    chk("mem", 8'(16 + 11), eeprom_dev_model_i.mem[3][2]);
    $display("test write done");
  endtask

  task automatic t_find();
    logic [15:0] bases [2] = '{16'd0, 16'd1};
    logic [15:0] hits [2] = '{16'd15, 16'd6};
    for (int k = 0; k < 2; k++) begin
      run_cmd(OP_FIND_EMPTY, bases[k], 0);
      chk("found", 1, res.found);
      chk("found_addr", hits[k], res.found_addr);
    end
    $display("test find done");
  endtask

  task automatic t_timeout();
    @(posedge sys_clk);
    #1 stuck = 1'b1;
    run_cmd(OP_WRITE_BLOCK, 20, 1);
    chk("timeout", 1, res.timeout);
    stuck = 1'b0;
    $display("test timeout done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_write();
    t_find();
    t_timeout();
    wrap_up();
  end

  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule // test_eeprom_array_host
`default_nettype wire
